// >>> design/dac_ctl_pkg.sv
// shared constants and types for the quad dac update control
package dac_ctl_pkg;
	localparam int         CODE_W     = 10;
	localparam int         CH_N       = 4;
	localparam int         WORD_W     = 24;
	localparam logic [4:0] ADDR_FIXED = 5'h03;
	// command codes in the top nibble of the command byte
	localparam logic [3:0] CMD_WR_IN  = 4'h1;
	localparam logic [3:0] CMD_UPD    = 4'h2;
	localparam logic [3:0] CMD_WR_UPD = 4'h3;
	localparam logic [3:0] CMD_POWER  = 4'h4;
	localparam logic [3:0] CMD_MASK   = 4'h5;
	localparam logic [3:0] CMD_SOFT   = 4'h6;
	// clear codes and reset values
	localparam logic [9:0] CODE_ZERO  = 10'h000;
	localparam logic [9:0] CODE_MID   = 10'h200;
	localparam logic [7:0] POWER_RST  = 8'h00;
	localparam logic [3:0] MASK_RST   = 4'h0;
	// frame word field positions
	localparam int         CMD_LSB    = 20;
	localparam int         SEL_LSB    = 16;
	localparam int         CODE_LSB   = 6;
	// bit slots within one byte on the link, and the index of the last byte of a write
	localparam logic [3:0] BYTE_LAST  = 4'h7;
	localparam logic [3:0] ACK_BIT    = 4'h8;
	localparam logic [1:0] WR_LAST    = 2'h2;
	// timing
	localparam int         CLK_NS        = 20;
	localparam int         RESET_MIN_NS  = 30;
	localparam int         RESET_MIN_CYC = (RESET_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [2:0] POR_CYC       = 3'h4;
	typedef enum logic [2:0] {LINK_IDLE, LINK_ADDR, LINK_WR, LINK_RD, LINK_SKIP} link_phase_e;
	typedef enum logic [1:0] {PWR_NORMAL, PWR_1K, PWR_100K, PWR_HIZ} power_mode_e;
endpackage

// >>> design/dac_link_engine.sv
// serial link engine on the link clock: byte framing, ack, readback
`timescale 1ns/10ps
module dac_link_engine (
	input  wire logic                                                       scl,
	input  wire logic                                                       sda_in,
	input  wire logic                                                       link_rst,
	input  wire logic                                                       addr_strap_hi,
	input  wire logic                                                       addr_strap_lo,
	input  wire logic [dac_ctl_pkg::CH_N-1:0][dac_ctl_pkg::CODE_W-1:0]      snap_codes,
	input  wire logic                                                       snap_tgl,
	output logic      [dac_ctl_pkg::WORD_W-1:0]                             frame_word,
	output logic                                                            frame_tgl,
	output logic                                                            sda_out,
	output logic                                                            sda_oe
);
	typedef struct packed {
		logic [1:0] st_s1;
		logic [1:0] st_s2;
		logic       sda_hi;
	} rise_s;

	typedef struct packed {
		dac_ctl_pkg::link_phase_e                            phase;
		logic [3:0]                                          cnt;
		logic [7:0]                                          sh;
		logic                                                rw;
		logic [1:0]                                          bidx;
		logic [dac_ctl_pkg::WORD_W-1:0]                      word;
		logic                                                tgl;
		logic                                                oe;
		logic                                                lvl;
		logic [7:0]                                          tx;
		logic                                                half;
		logic [1:0]                                          ptr;
		logic                                                sn_s1;
		logic                                                sn_s2;
		logic                                                sn_seen;
		logic [dac_ctl_pkg::CH_N-1:0][dac_ctl_pkg::CODE_W-1:0] rb;
	} fall_s;

	rise_s      r_reg;
	rise_s      r_next;
	fall_s      f_reg;
	fall_s      f_next;
	logic [7:0] sh_new;
	logic [1:0] ptr_nxt;
	logic [9:0] code_cur;
	logic [9:0] code_nxt;
	logic       match;

	// data bit is sampled while scl is high; straps pass two flops
	always_comb begin
		r_next        = r_reg;
		r_next.sda_hi = sda_in;
		r_next.st_s1  = {addr_strap_hi, addr_strap_lo};
		r_next.st_s2  = r_reg.st_s1;
	end

	// all framing moves on the falling edge, so our drive changes while scl is low
	always_comb begin
		f_next   = f_reg;
		sh_new   = {f_reg.sh[6:0], r_reg.sda_hi};
		ptr_nxt  = f_reg.ptr + 2'h1;
		code_cur = f_reg.rb[f_reg.ptr];
		code_nxt = f_reg.rb[ptr_nxt];
		match    = (sh_new[7:1] == {dac_ctl_pkg::ADDR_FIXED, r_reg.st_s2});
		f_next.sn_s1 = snap_tgl;
		f_next.sn_s2 = f_reg.sn_s1;
		if (f_reg.sn_s2 != f_reg.sn_seen) begin
			f_next.sn_seen = f_reg.sn_s2;
			f_next.rb      = snap_codes;
		end
		// idle treats the next fall as the end of a start, since stop leaves no fall
		if (f_reg.phase == dac_ctl_pkg::LINK_IDLE || (r_reg.sda_hi && !sda_in)) begin
			f_next.phase = dac_ctl_pkg::LINK_ADDR;
			f_next.cnt   = 4'h0;
			f_next.bidx  = 2'h0;
			f_next.oe    = 1'b0;
		end else if (f_reg.cnt != dac_ctl_pkg::ACK_BIT) begin
			f_next.cnt = f_reg.cnt + 4'h1;
			f_next.sh  = sh_new;
			if (f_reg.phase == dac_ctl_pkg::LINK_RD) begin
				f_next.tx = {f_reg.tx[6:0], 1'b0};
				f_next.oe = (f_reg.cnt == dac_ctl_pkg::BYTE_LAST) ? 1'b0 : !f_reg.tx[6];
			end else if (f_reg.cnt == dac_ctl_pkg::BYTE_LAST) begin
				f_next.oe = (f_reg.phase == dac_ctl_pkg::LINK_WR) ||
				            (f_reg.phase == dac_ctl_pkg::LINK_ADDR && match);
				f_next.rw = sh_new[0];
			end
		end else begin
			f_next.cnt = 4'h0;
			f_next.oe  = 1'b0;
			case (f_reg.phase)
				dac_ctl_pkg::LINK_ADDR: begin
					if (!f_reg.oe) begin
						f_next.phase = dac_ctl_pkg::LINK_SKIP;
					end else if (f_reg.rw) begin
						f_next.phase = dac_ctl_pkg::LINK_RD;
						f_next.half  = 1'b0;
						f_next.tx    = code_cur[9:2];
						f_next.oe    = !code_cur[9];
					end else begin
						f_next.phase = dac_ctl_pkg::LINK_WR;
					end
				end
				dac_ctl_pkg::LINK_WR: begin
					f_next.word = {f_reg.word[15:0], f_reg.sh};
					f_next.bidx = f_reg.bidx + 2'h1;
					if (f_reg.bidx == 2'h0) begin
						// first selected channel starts the readback
						f_next.ptr = f_reg.sh[0] ? 2'h0 : f_reg.sh[1] ? 2'h1 :
						             f_reg.sh[2] ? 2'h2 : f_reg.sh[3] ? 2'h3 : 2'h0;
					end
					if (f_reg.bidx == dac_ctl_pkg::WR_LAST) begin
						f_next.tgl   = !f_reg.tgl;
						f_next.phase = dac_ctl_pkg::LINK_IDLE;
					end
				end
				dac_ctl_pkg::LINK_RD: begin
					if (r_reg.sda_hi) begin
						f_next.phase = dac_ctl_pkg::LINK_IDLE;
					end else if (!f_reg.half) begin
						f_next.half = 1'b1;
						f_next.tx   = {code_cur[1:0], 6'h00};
						f_next.oe   = !code_cur[1];
					end else begin
						f_next.half = 1'b0;
						f_next.ptr  = ptr_nxt;
						f_next.tx   = code_nxt[9:2];
						f_next.oe   = !code_nxt[9];
					end
				end
				default: begin
					f_next.phase = f_reg.phase;
				end
			endcase
		end
	end

	// asynchronous reset: the link clock stands still while the system resets
	always_ff @(posedge scl or posedge link_rst) begin
		if (link_rst) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	always_ff @(negedge scl or posedge link_rst) begin
		if (link_rst) begin
			f_reg <= '0;
		end else begin
			f_reg <= f_next;
		end
	end

	assign frame_word = f_reg.word;
	assign frame_tgl  = f_reg.tgl;
	assign sda_out    = f_reg.lvl;
	assign sda_oe     = f_reg.oe;
endmodule

// >>> design/quad_dac_update_control.sv
// quad dac update control: register banks, strobe, resets, link engine
`timescale 1ns/10ps
module quad_dac_update_control #(
	parameter logic [2:0] POR_LEN = dac_ctl_pkg::POR_CYC
) (
	input  wire logic       mclk,
	input  wire logic       reset,
	input  wire logic       scl,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	input  wire logic       addr_strap_hi,
	input  wire logic       addr_strap_lo,
	input  wire logic       load_strobe_n,
	input  wire logic       hw_reset_n,
	input  wire logic       reset_level_select,
	output logic      [9:0] dac_a_code,
	output logic      [9:0] dac_b_code,
	output logic      [9:0] dac_c_code,
	output logic      [9:0] dac_d_code,
	output logic      [1:0] power_mode_a,
	output logic      [1:0] power_mode_b,
	output logic      [1:0] power_mode_c,
	output logic      [1:0] power_mode_d,
	output logic      [3:0] chan_powered_down
);
	localparam int CH = dac_ctl_pkg::CH_N;
	localparam int CW = dac_ctl_pkg::CODE_W;

	// init length must cover the busy checks below and fit the counter
	if (POR_LEN < 3'h4) $error("POR_LEN must be at least 4");
	// the pin synchroniser catches any low pulse of one clock or longer
	if (dac_ctl_pkg::RESET_MIN_CYC < 1) $error("reset pulse shorter than a clock");

	typedef struct packed {
		logic                  ls_s1;
		logic                  ls_s2;
		logic                  ls_s3;
		logic                  hr_s1;
		logic                  hr_s2;
		logic                  rs_s1;
		logic                  rs_s2;
		logic                  ft_s1;
		logic                  ft_s2;
		logic                  ft_s3;
		logic                  link_rst;
		logic [2:0]            por_cnt;
		logic [CH-1:0][CW-1:0] inreg;
		logic [CH-1:0][CW-1:0] dac;
		logic [CH-1:0][CW-1:0] snap;
		logic                  snap_tgl;
		logic [7:0]            power;
		logic [3:0]            mask;
		logic [3:0]            pd;
	} ctl_s;

	ctl_s                            s_reg;
	ctl_s                            s_next;
	logic [dac_ctl_pkg::WORD_W-1:0]  frame_word;
	logic                            frame_tgl;
	logic                            busy;
	logic                            strobe_fall;
	logic                            strobe_low;
	logic                            frame_new;
	logic [3:0]                      cmd_now;
	logic [3:0]                      sel_now;
	logic [CW-1:0]                   code_now;
	logic [CW-1:0]                   clear_code;

	dac_link_engine u_link (
		.scl           (scl),
		.sda_in        (sda_in),
		.link_rst      (s_reg.link_rst),
		.addr_strap_hi (addr_strap_hi),
		.addr_strap_lo (addr_strap_lo),
		.snap_codes    (s_reg.snap),
		.snap_tgl      (s_reg.snap_tgl),
		.frame_word    (frame_word),
		.frame_tgl     (frame_tgl),
		.sda_out       (sda_out),
		.sda_oe        (sda_oe)
	);

	// the frame word stands still after its toggle moves until the next frame's command byte
	assign frame_new   = s_reg.ft_s2 ^ s_reg.ft_s3;
	assign cmd_now     = frame_word[dac_ctl_pkg::CMD_LSB +: 4];
	assign sel_now     = frame_word[dac_ctl_pkg::SEL_LSB +: 4];
	assign code_now    = frame_word[dac_ctl_pkg::CODE_LSB +: CW];
	assign strobe_fall = s_reg.ls_s3 & ~s_reg.ls_s2;
	assign strobe_low  = ~s_reg.ls_s2;
	assign busy        = ~s_reg.hr_s2 | (s_reg.por_cnt != 3'h0);
	assign clear_code  = s_reg.rs_s2 ? dac_ctl_pkg::CODE_MID : dac_ctl_pkg::CODE_ZERO;

	// the strobe edge is seen two clocks late; a true async copy is traded for one domain
	always_comb begin
		s_next          = s_reg;
		s_next.link_rst = 1'b0;
		s_next.ls_s1    = load_strobe_n;
		s_next.ls_s2    = s_reg.ls_s1;
		s_next.ls_s3    = s_reg.ls_s2;
		s_next.hr_s1    = hw_reset_n;
		s_next.hr_s2    = s_reg.hr_s1;
		s_next.rs_s1    = reset_level_select;
		s_next.rs_s2    = s_reg.rs_s1;
		s_next.ft_s1    = frame_tgl;
		s_next.ft_s2    = s_reg.ft_s1;
		s_next.ft_s3    = s_reg.ft_s2;
		if (busy) begin
			// init holds all stages at the clear code; strobe and frames are dropped
			for (int i = 0; i < CH; i++) begin
				s_next.inreg[i] = clear_code;
				s_next.dac[i]   = clear_code;
			end
			s_next.power   = dac_ctl_pkg::POWER_RST;
			s_next.mask    = dac_ctl_pkg::MASK_RST;
			s_next.por_cnt = !s_reg.hr_s2 ? POR_LEN : s_reg.por_cnt - 3'h1;
		end else begin
			if (strobe_fall) begin
				for (int i = 0; i < CH; i++) begin
					if (!s_reg.mask[i]) begin
						s_next.dac[i] = s_reg.inreg[i];
					end
				end
			end
			if (frame_new) begin
				case (cmd_now)
					dac_ctl_pkg::CMD_WR_IN: begin
						for (int i = 0; i < CH; i++) begin
							if (sel_now[i]) begin
								s_next.inreg[i] = code_now;
								if (strobe_low && !s_reg.mask[i]) begin
									s_next.dac[i] = code_now;
								end
							end
						end
					end
					dac_ctl_pkg::CMD_UPD: begin
						for (int i = 0; i < CH; i++) begin
							if (sel_now[i]) begin
								s_next.dac[i] = s_reg.inreg[i];
							end
						end
					end
					dac_ctl_pkg::CMD_WR_UPD: begin
						// lands even on a powered-down channel
						for (int i = 0; i < CH; i++) begin
							if (sel_now[i]) begin
								s_next.inreg[i] = code_now;
								s_next.dac[i]   = code_now;
							end
						end
					end
					dac_ctl_pkg::CMD_POWER: begin
						s_next.power = frame_word[7:0];
					end
					dac_ctl_pkg::CMD_MASK: begin
						s_next.mask = frame_word[3:0];
					end
					dac_ctl_pkg::CMD_SOFT: begin
						s_next.por_cnt = POR_LEN;
					end
					default: begin
						s_next.por_cnt = s_reg.por_cnt;
					end
				endcase
			end
		end
		// any nonzero pair means the channel is powered down
		for (int i = 0; i < CH; i++) begin
			s_next.pd[i] = |s_reg.power[2*i +: 2];
		end
		// readback copy; changes are a frame apart, so the toggle settles first
		if (s_reg.inreg != s_reg.snap) begin
			s_next.snap     = s_reg.inreg;
			s_next.snap_tgl = !s_reg.snap_tgl;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			s_reg          <= '0;
			s_reg.ls_s1    <= 1'b1;
			s_reg.ls_s2    <= 1'b1;
			s_reg.ls_s3    <= 1'b1;
			s_reg.link_rst <= 1'b1;
			s_reg.por_cnt  <= POR_LEN;
		end else begin
			s_reg <= s_next;
		end
	end

	// channel order a, b, c, d follows bit order zero to three
	assign dac_a_code        = s_reg.dac[0];
	assign dac_b_code        = s_reg.dac[1];
	assign dac_c_code        = s_reg.dac[2];
	assign dac_d_code        = s_reg.dac[3];
	assign power_mode_a      = s_reg.power[1:0];
	assign power_mode_b      = s_reg.power[3:2];
	assign power_mode_c      = s_reg.power[5:4];
	assign power_mode_d      = s_reg.power[7:6];
	assign chan_powered_down = s_reg.pd;

	chk_strobe_copy: assert property (@(posedge mclk) disable iff (reset)
		(!busy && strobe_fall && !frame_new && !s_reg.mask[0]) |=>
		(s_reg.dac[0] == $past(s_reg.inreg[0])))
		else $error("strobe edge did not copy channel a");
	chk_mask_block: assert property (@(posedge mclk) disable iff (reset)
		(!busy && strobe_fall && !frame_new && s_reg.mask[2]) |=> $stable(s_reg.dac[2]))
		else $error("masked channel followed the strobe");
	chk_wr_in_low: assert property (@(posedge mclk) disable iff (reset)
		(!busy && frame_new && cmd_now == dac_ctl_pkg::CMD_WR_IN && sel_now[1] &&
		strobe_low && !s_reg.mask[1]) |=> (s_reg.dac[1] == $past(code_now)))
		else $error("write with strobe low missed the dac stage");
	chk_wr_in_high: assert property (@(posedge mclk) disable iff (reset)
		(!busy && frame_new && cmd_now == dac_ctl_pkg::CMD_WR_IN && sel_now[2] &&
		!strobe_low && !strobe_fall) |=>
		($stable(s_reg.dac[2]) && s_reg.inreg[2] == $past(code_now)))
		else $error("write with strobe high misbehaved");
	chk_upd_cmd: assert property (@(posedge mclk) disable iff (reset)
		(!busy && frame_new && cmd_now == dac_ctl_pkg::CMD_UPD && sel_now[2]) |=>
		(s_reg.dac[2] == $past(s_reg.inreg[2])))
		else $error("update command did not copy channel c");
	chk_wr_upd: assert property (@(posedge mclk) disable iff (reset)
		(!busy && frame_new && cmd_now == dac_ctl_pkg::CMD_WR_UPD && sel_now[1]) |=>
		(s_reg.dac[1] == $past(code_now) && s_reg.inreg[1] == $past(code_now)))
		else $error("write and update missed channel b");
	chk_power_load: assert property (@(posedge mclk) disable iff (reset)
		(!busy && frame_new && cmd_now == dac_ctl_pkg::CMD_POWER) |=>
		(s_reg.power == $past(frame_word[7:0])) ##1 (s_reg.pd[3] == |s_reg.power[7:6]))
		else $error("power field not loaded");
	chk_mask_load: assert property (@(posedge mclk) disable iff (reset)
		(!busy && frame_new && cmd_now == dac_ctl_pkg::CMD_MASK) |=>
		(s_reg.mask == $past(frame_word[3:0])))
		else $error("mask not loaded");
	chk_soft_reset: assert property (@(posedge mclk) disable iff (reset)
		(!busy && frame_new && cmd_now == dac_ctl_pkg::CMD_SOFT) |=> busy [*4])
		else $error("software reset did not hold init");
	chk_hold_off: assert property (@(posedge mclk) disable iff (reset)
		$rose(s_reg.hr_s2) |-> busy [*3])
		else $error("init ended with the reset pin");
	chk_clear_value: assert property (@(posedge mclk) disable iff (reset)
		busy |=> (s_reg.dac[3] == $past(clear_code) && s_reg.mask == 4'h0))
		else $error("init did not clear the outputs");
	chk_busy_strobe: assert property (@(posedge mclk) disable iff (reset)
		(busy && strobe_fall) |=> (s_reg.dac[1] == $past(clear_code)))
		else $error("strobe acted during init");
	chk_snap_follow: assert property (@(posedge mclk) disable iff (reset)
		(s_reg.inreg != s_reg.snap) |=> (s_reg.snap == $past(s_reg.inreg)))
		else $error("readback copy lagged");

	// settings move only on a completed frame or during init
	chk_power_hold: assert property (@(posedge mclk) disable iff (reset)
		(!busy && !frame_new) |=> $stable(s_reg.power))
		else $error("power field moved without a frame");
	chk_mask_hold: assert property (@(posedge mclk) disable iff (reset)
		(!busy && !frame_new) |=> $stable(s_reg.mask))
		else $error("mask moved without a frame");
	// a low reset pin pins both stages to the clear code
	chk_pin_clear: assert property (@(posedge mclk) disable iff (reset)
		!s_reg.hr_s2 |=> (s_reg.dac[0] == $past(clear_code) &&
		s_reg.inreg[0] == $past(clear_code)))
		else $error("stages moved while the reset pin was low");
	// without a frame or a strobe edge the dac stage holds
	chk_dac_idle: assert property (@(posedge mclk) disable iff (reset)
		(!busy && !frame_new && !strobe_fall) |=> $stable(s_reg.dac))
		else $error("dac stage moved with nothing asking");
	// reserved codes touch neither stage
	chk_reserved_drop: assert property (@(posedge mclk) disable iff (reset)
		(!busy && frame_new && cmd_now[3] && !strobe_fall) |=>
		($stable(s_reg.dac) && $stable(s_reg.inreg)))
		else $error("reserved command changed a stage");
	// channel b flag follows its own pair, one clock later
	chk_pd_map: assert property (@(posedge mclk) disable iff (reset)
		1'b1 |=> (s_reg.pd[1] == ($past(s_reg.power[3:2]) != 2'h0)))
		else $error("powered-down flag of channel b is wrong");
	// the readback toggle only moves when the copy is refreshed
	chk_snap_quiet: assert property (@(posedge mclk) disable iff (reset)
		(s_reg.inreg == s_reg.snap) |=> $stable(s_reg.snap_tgl))
		else $error("readback toggle moved without new data");
endmodule

// >>> verification/link_master_model.sv
// bus master model: drives the link clock and data wire, reads back device answers
`timescale 1ns/10ps
module link_master_model (
	output logic      scl,
	output logic      sda_m,
	input  wire logic sda_w
);
	// clock parked high and wire released between frames, as on a pulled-up bus
	initial begin
		scl = 1'h1;
		sda_m = 1'h1;
	end
	// data moves early in the low phase so it never races the device's scl fall
	task automatic bit_slot(input logic b, output logic r);
		#20 sda_m = b;
		#60 scl = 1'h1;
		#40 r = sda_w;
		#40 scl = 1'h0;
	endtask
	// from a low clock this is a repeated start: lift the wire, then the clock
	task automatic start();
		if (scl === 1'h0) begin
			#20 sda_m = 1'h1;
			#60 scl = 1'h1;
		end
		#40 sda_m = 1'h0;
		#40 scl = 1'h0;
	endtask
	task automatic stop();
		#20 sda_m = 1'h0;
		#60 scl = 1'h1;
		#40 sda_m = 1'h1;
		#40;
	endtask
	// msb first, then the wire is released for the ack slot
	task automatic wr_byte(input logic [7:0] b, output logic nak);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_slot(b[i], r);
		end
		bit_slot(1'h1, nak);
	endtask
	task automatic rd_byte(input logic last, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_slot(1'h1, r);
			b[i] = r;
		end
		bit_slot(last, r);
	endtask
	// address, command, data high, data low, stop
	task automatic frame(input logic [6:0] a, input logic [23:0] w, output logic nak);
		logic n0, n1, n2, n3;
		start();
		wr_byte({a, 1'h0}, n0);
		wr_byte(w[23:16], n1);
		wr_byte(w[15:8], n2);
		wr_byte(w[7:0], n3);
		stop();
		nak = n0 | n1 | n2 | n3;
	endtask
	// first channel chosen by the command byte, then two bytes per channel
	task automatic readback(input logic [6:0] a, input logic [3:0] sel, input int n,
			output logic [4:0][15:0] v);
		logic       nk;
		logic [7:0] hi, lo;
		v = '0;
		start();
		wr_byte({a, 1'h0}, nk);
		wr_byte({dac_ctl_pkg::CMD_WR_IN, sel}, nk);
		start();
		wr_byte({a, 1'h1}, nk);
		for (int i = 0; i < n; i++) begin
			rd_byte(1'h0, hi);
			rd_byte(i == n - 1, lo);
			v[i] = {hi, lo};
		end
		stop();
	endtask
endmodule

// >>> verification/tb_top.sv
// self-checking bench for the quad dac update control
`timescale 1ns/10ps
module tb_top;
	localparam logic [6:0] ADDR = {dac_ctl_pkg::ADDR_FIXED, 2'h2};
	logic             mclk, reset, load_strobe_n, hw_reset_n, reset_level_select;
	logic             scl, sda_m, sda_out, sda_oe, sda_w, nak;
	logic       [9:0] dac_a_code, dac_b_code, dac_c_code, dac_d_code;
	logic       [1:0] power_mode_a, power_mode_b, power_mode_c, power_mode_d;
	logic       [3:0] chan_powered_down;
	logic      [39:0] codes;
	logic       [7:0] pwr;
	logic [4:0][15:0] rb;
	int               errors, n_compared;
	// open-drain wire with pull-up: either party may pull it low
	assign sda_w = sda_m & ~(sda_oe & ~sda_out);
	assign codes = {dac_d_code, dac_c_code, dac_b_code, dac_a_code};
	assign pwr = {power_mode_d, power_mode_c, power_mode_b, power_mode_a};
	initial begin
		mclk = 1'h0;
		forever #10 mclk = ~mclk;
	end
	link_master_model master (.scl(scl), .sda_m(sda_m), .sda_w(sda_w));
	quad_dac_update_control DUT (
		.mclk(mclk), .reset(reset), .scl(scl), .sda_in(sda_w), .sda_out(sda_out),
		.sda_oe(sda_oe), .addr_strap_hi(1'h1), .addr_strap_lo(1'h0),
		.load_strobe_n(load_strobe_n), .hw_reset_n(hw_reset_n),
		.reset_level_select(reset_level_select), .dac_a_code(dac_a_code),
		.dac_b_code(dac_b_code), .dac_c_code(dac_c_code), .dac_d_code(dac_d_code),
		.power_mode_a(power_mode_a), .power_mode_b(power_mode_b),
		.power_mode_c(power_mode_c), .power_mode_d(power_mode_d),
		.chan_powered_down(chan_powered_down)
	);
	task automatic chk_word(input logic [39:0] got, input logic [39:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_flag(input logic got, input logic exp);
		chk_word({39'h0, got}, {39'h0, exp});
	endtask
	task automatic close_out();
		$display("compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// inputs always change 2 ns after a rising edge
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#2;
	endtask
	// one write frame, then enough cycles for the cross and apply
	task automatic send(input logic [3:0] cmd, input logic [3:0] sel, input logic [15:0] d);
		master.frame(ADDR, {cmd, sel, d}, nak);
		cyc(1);
		chk_flag(nak, 1'h0);
		cyc(12);
	endtask
	task automatic pulse();
		load_strobe_n = 1'h0;
		cyc(4);
		load_strobe_n = 1'h1;
		cyc(8);
	endtask
	task automatic t_defer();
		send(dac_ctl_pkg::CMD_WR_IN, 4'h1, {10'h155, 6'h0});
		chk_word(codes, {4{10'h200}});
		pulse();
		chk_word(codes, {10'h200, 10'h200, 10'h200, 10'h155});
		$display("test deferred update finished");
	endtask
	task automatic t_now();
		load_strobe_n = 1'h0;
		cyc(8);
		send(dac_ctl_pkg::CMD_WR_IN, 4'h2, {10'h0ab, 6'h0});
		load_strobe_n = 1'h1;
		cyc(8);
		chk_word(codes, {10'h200, 10'h200, 10'h0ab, 10'h155});
		$display("test immediate update finished");
	endtask
	task automatic t_cmds();
		send(dac_ctl_pkg::CMD_WR_IN, 4'h4, {10'h3ff, 6'h0});
		chk_word(codes, {10'h200, 10'h200, 10'h0ab, 10'h155});
		send(dac_ctl_pkg::CMD_UPD, 4'h4, 16'h0);
		chk_word(codes, {10'h200, 10'h3ff, 10'h0ab, 10'h155});
		send(dac_ctl_pkg::CMD_WR_UPD, 4'h8, {10'h001, 6'h0});
		chk_word(codes, {10'h001, 10'h3ff, 10'h0ab, 10'h155});
		send(4'h8, 4'hf, 16'hffc0);
		chk_word(codes, {10'h001, 10'h3ff, 10'h0ab, 10'h155});
		$display("test update commands finished");
	endtask
	task automatic t_read();
		logic [4:0][9:0] e;
		e = {10'h001, 10'h3ff, 10'h0ab, 10'h155, 10'h001};
		master.readback(ADDR, 4'h8, 5, rb);
		for (int i = 0; i < 5; i++) begin
			chk_word({24'h0, rb[i]}, {24'h0, e[i], 6'h0});
		end
		$display("test readback finished");
	endtask
	task automatic t_mask();
		send(dac_ctl_pkg::CMD_MASK, 4'hf, 16'h0005);
		send(dac_ctl_pkg::CMD_WR_IN, 4'h3, {10'h111, 6'h0});
		pulse();
		chk_word(codes, {10'h001, 10'h3ff, 10'h111, 10'h155});
		send(dac_ctl_pkg::CMD_MASK, 4'h0, 16'h0000);
		pulse();
		chk_word(codes, {10'h001, 10'h3ff, 10'h111, 10'h111});
		$display("test strobe mask finished");
	endtask
	task automatic t_power();
		send(dac_ctl_pkg::CMD_POWER, 4'h0, 16'h00e4);
		chk_word({32'h0, pwr}, 40'he4);
		chk_word({36'h0, chan_powered_down}, 40'he);
		send(dac_ctl_pkg::CMD_WR_UPD, 4'h2, {10'h222, 6'h0});
		chk_word(codes, {10'h001, 10'h3ff, 10'h222, 10'h111});
		$display("test power modes finished");
	endtask
	// a foreign address is ignored; only a repeated start wakes the device
	task automatic t_addr();
		master.start();
		master.wr_byte({dac_ctl_pkg::ADDR_FIXED, 2'h1, 1'h0}, nak);
		chk_flag(nak, 1'h1);
		send(dac_ctl_pkg::CMD_WR_UPD, 4'h1, {10'h0aa, 6'h0});
		chk_word(codes, {10'h001, 10'h3ff, 10'h222, 10'h0aa});
		$display("test address match finished");
	endtask
	task automatic t_hwrst();
		reset_level_select = 1'h0;
		cyc(4);
		hw_reset_n = 1'h0;
		load_strobe_n = 1'h0;
		cyc(2);
		hw_reset_n = 1'h1;
		load_strobe_n = 1'h1;
		cyc(12);
		chk_word(codes, 40'h0);
		chk_word({32'h0, pwr}, 40'h0);
		cyc(50);
		chk_word(codes, 40'h0);
		send(dac_ctl_pkg::CMD_WR_UPD, 4'h1, {10'h0f0, 6'h0});
		chk_word(codes, {30'h0, 10'h0f0});
		$display("test hardware reset finished");
	endtask
	task automatic t_soft();
		reset_level_select = 1'h1;
		cyc(4);
		send(dac_ctl_pkg::CMD_SOFT, 4'h0, 16'h0);
		chk_word(codes, {4{10'h200}});
		$display("test soft reset finished");
	endtask
	// watchdog: a hang counts as a mismatch
	initial begin
		repeat (100000) @(posedge mclk);
		errors++;
		close_out();
	end
	initial begin
		errors = 0;
		n_compared = 0;
		reset = 1'h1;
		load_strobe_n = 1'h1;
		hw_reset_n = 1'h0;
		reset_level_select = 1'h1;
		cyc(10);
		reset = 1'h0;
		cyc(20);
		hw_reset_n = 1'h1;
		cyc(60);
		chk_word(codes, {4{10'h200}});
		t_defer();
		t_now();
		t_cmds();
		t_read();
		t_mask();
		t_power();
		t_addr();
		t_hwrst();
		t_soft();
		close_out();
	end
endmodule
